//--- design/par_top.sv
// Per-port conversion result registers with completion flags and interrupt.
// Assumes the converter events come from logic on clk_i, and a classic
// Wishbone master; byte address = port * 64 + select code * 4.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`include "par_map.svh"

module par_top
    import par_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Converter events
    input wire par_conv_t conv_start_i,
    input wire par_conv_t conv_done_i,
    // Interrupt
    output logic irq_o
);

    par_state_t q_r;
    par_state_t q_nxt;

    // Address decode
    logic [1:0] adr_prt;
    logic [3:0] adr_idx;
    logic [1:0] adr_kind;
    logic take;
    logic rd_take;
    logic wr_take;
    assign adr_prt = wb_adr_i[`PAR_ADR_PORT_HI:`PAR_ADR_PORT_LO];
    assign adr_idx = wb_adr_i[`PAR_ADR_IDX_HI:`PAR_ADR_IDX_LO];
    assign adr_kind = adr_idx[2:1];
    assign take = wb_cyc_i & wb_stb_i & ~q_r.ack;
    assign rd_take = take & ~wb_we_i;
    assign wr_take = take & wb_we_i;

    // Event vectors from the converter
    logic start_ok;
    logic done_ok;
    assign start_ok = conv_start_i.valid & (conv_start_i.kind != 2'h3);
    assign done_ok = conv_done_i.valid & (conv_done_i.kind != 2'h3);

    // Read data for the addressed register
    logic [31:0] rd_data;
    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (adr_idx[3] && adr_kind != 2'h3)
        begin
            if (adr_idx[0])
            begin
                rd_data[`PAR_FLAG_BIT] = q_r.done[adr_prt][adr_kind];
                rd_data[6:0] = q_r.res[adr_prt][adr_kind][14:8];
            end
            else
            begin
                rd_data[7:0] = q_r.res[adr_prt][adr_kind][7:0];
            end
        end
        else if (adr_prt == 2'h0 && adr_idx == `PAR_IDX_STATUS)
        begin
            rd_data[11:0] = q_r.sts;
        end
        else if (adr_prt == 2'h0 && adr_idx == `PAR_IDX_MASK)
        begin
            rd_data[11:0] = q_r.msk;
        end
    end

    // Byte-lane write data for the 12-bit status and mask
    logic [11:0] wr_bits;
    logic [11:0] wr_lane;
    assign wr_bits = wb_dat_i[11:0];
    assign wr_lane = {{4{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Next state
    always_comb
    begin
        par_flags_t set_v;
        set_v = '0;
        q_nxt = q_r;
        // Bus answer one cycle after the request is taken
        q_nxt.ack = take;
        if (rd_take)
        begin
            q_nxt.dat = rd_data;
        end
        if (start_ok)
        begin
            q_nxt.done[conv_start_i.port][conv_start_i.kind] = 1'b0;
        end
        if (done_ok)
        begin
            q_nxt.res[conv_done_i.port][conv_done_i.kind] = conv_done_i.data;
            q_nxt.done[conv_done_i.port][conv_done_i.kind] = 1'b1;
            set_v[conv_done_i.port][conv_done_i.kind] = 1'b1;
        end
        // Mask write and write-one-to-clear status, set wins
        if (wr_take && adr_prt == 2'h0 && adr_idx == `PAR_IDX_MASK)
        begin
            q_nxt.msk = (q_r.msk & ~wr_lane) | (wr_bits & wr_lane);
        end
        if (wr_take && adr_prt == 2'h0 && adr_idx == `PAR_IDX_STATUS)
        begin
            q_nxt.sts = q_r.sts & ~(wr_bits & wr_lane);
        end
        q_nxt.sts = q_nxt.sts | set_v;
        q_nxt.irq = |(q_nxt.sts & q_nxt.msk);
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q_r <= '0;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o = q_r.dat;
    assign wb_ack_o = q_r.ack;
    assign irq_o = q_r.irq;

    // Helpers for checks: addressed port's results and flags, and port 0 voltage result
    logic [2:0][14:0] sel_res;
    logic [2:0] sel_done;
    logic [14:0] p0_volt;
    assign sel_res = q_r.res[adr_prt];
    assign sel_done = q_r.done[adr_prt];
    assign p0_volt = q_r.res[0][0];

    AST_VOLT_LO: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_take && adr_idx == `PAR_IDX_VOLT_LO
        |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(sel_res[0][7:0])})
        else $error("voltage low readback wrong");

    AST_VOLT_HI: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_take && adr_idx == `PAR_IDX_VOLT_HI
        |=> wb_dat_o == {24'h00_0000, $past(sel_done[0]), $past(sel_res[0][14:8])})
        else $error("voltage high readback wrong");

    AST_VOLT_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        start_ok && conv_start_i.kind == `PAR_KIND_VOLT && !done_ok
        |=> !q_r.done[$past(conv_start_i.port)][0])
        else $error("voltage flag not cleared at start");

    AST_VOLT_SET: assert property (@(posedge clk_i) disable iff (rst_i)
        done_ok && conv_done_i.kind == `PAR_KIND_VOLT
        |=> q_r.done[$past(conv_done_i.port)][0])
        else $error("voltage flag not set at finish");

    AST_CURR_HI: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_take && adr_idx == `PAR_IDX_CURR_HI
        |=> wb_dat_o == {24'h00_0000, $past(sel_done[1]), $past(sel_res[1][14:8])})
        else $error("current high readback wrong");

    AST_CURR_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        start_ok && conv_start_i.kind == `PAR_KIND_CURR && !done_ok
        |=> !q_r.done[$past(conv_start_i.port)][1])
        else $error("current flag not cleared at start");

    // current finish sets flag and raises status in the same cycle
    AST_CURR_SET: assert property (@(posedge clk_i) disable iff (rst_i)
        done_ok && conv_done_i.kind == `PAR_KIND_CURR
        |=> q_r.done[$past(conv_done_i.port)][1] && q_r.sts[$past(conv_done_i.port)][1])
        else $error("current flag or status not set");

    AST_TEMP_LO: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_take && adr_idx == `PAR_IDX_TEMP_LO
        |=> wb_dat_o == {24'h00_0000, $past(sel_res[2][7:0])})
        else $error("temperature low readback wrong");

    AST_TEMP_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        start_ok && conv_start_i.kind == `PAR_KIND_TEMP && !done_ok
        |=> !q_r.done[$past(conv_start_i.port)][2])
        else $error("temperature flag not cleared at start");

    AST_TEMP_SET: assert property (@(posedge clk_i) disable iff (rst_i)
        done_ok && conv_done_i.kind == `PAR_KIND_TEMP
        |=> q_r.done[$past(conv_done_i.port)][2])
        else $error("temperature flag not set at finish");

    // other ports leave port 0 voltage untouched
    AST_PORT_SEP: assert property (@(posedge clk_i) disable iff (rst_i)
        done_ok && conv_done_i.port != 2'h0
        |=> $stable(p0_volt))
        else $error("port results not separate");

    // flag rises only with new result
    AST_ATOMIC: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(q_r.done[0][0])
        |-> $past(done_ok) && p0_volt == $past(conv_done_i.data))
        else $error("flag and result not updated together");

    // Interrupt rises with masked status, one cycle after the event
    AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
        done_ok && q_r.msk[conv_done_i.port][conv_done_i.kind] |=> irq_o)
        else $error("interrupt missing after masked event");

    AST_CURR_LO: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_take && adr_idx == `PAR_IDX_CURR_LO
        |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(sel_res[1][7:0])})
        else $error("current low readback wrong");

    AST_TEMP_HI: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_take && adr_idx == `PAR_IDX_TEMP_HI
        |=> wb_dat_o == {24'h00_0000, $past(sel_done[2]), $past(sel_res[2][14:8])})
        else $error("temperature high readback wrong");

    // Start alone keeps the old result bits
    AST_START_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        start_ok && !done_ok
        |=> $stable(q_r.res))
        else $error("conversion start changed result bits");

    // finish beats a start in the same slot
    AST_DONE_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
        done_ok && start_ok && conv_start_i.port == conv_done_i.port
        && conv_start_i.kind == conv_done_i.kind
        |=> q_r.done[$past(conv_done_i.port)][$past(conv_done_i.kind)])
        else $error("start overrode finish in the same cycle");

    // Acknowledge stands for one cycle only
    AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o
        |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");

    // Every taken request is answered in the next cycle
    AST_ACK_NEXT: assert property (@(posedge clk_i) disable iff (rst_i)
        take
        |=> wb_ack_o)
        else $error("acknowledge missing after request");

    // Writing ones clears status bits when no event lands
    AST_STS_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && adr_prt == 2'h0 && adr_idx == `PAR_IDX_STATUS && !done_ok
        |=> (q_r.sts & $past(wr_bits & wr_lane)) == 12'h000)
        else $error("status bits not cleared by write");

    // Every finish raises its status bit
    AST_STS_SET: assert property (@(posedge clk_i) disable iff (rst_i)
        done_ok
        |=> q_r.sts[$past(conv_done_i.port)][$past(conv_done_i.kind)])
        else $error("status bit not set at finish");

    // Read data stands until the next read is taken
    AST_RD_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !rd_take
        |=> $stable(wb_dat_o))
        else $error("read data changed without a read");

    // Writes to result registers are ignored
    AST_WR_RO: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && adr_idx[3] && !done_ok
        |=> $stable(q_r.res))
        else $error("result register changed by a write");

endmodule : par_top

//--- design/par_map.svh
// Offsets, field positions and reset values of the port result registers.
// Assumes a Wishbone slave with a byte address of 8 bits and 32-bit data.
`ifndef PAR_MAP_SVH
`define PAR_MAP_SVH

// Port count, quantities per port and result width
`define PAR_PORTS 4
`define PAR_KINDS 3
`define PAR_RES_W 15

// Quantity codes on the converter side
`define PAR_KIND_VOLT 2'h0
`define PAR_KIND_CURR 2'h1
`define PAR_KIND_TEMP 2'h2

// Register select codes, byte address is four times the code
`define PAR_IDX_STATUS 4'h0
`define PAR_IDX_MASK 4'h1
`define PAR_IDX_VOLT_LO 4'h8
`define PAR_IDX_VOLT_HI 4'h9
`define PAR_IDX_CURR_LO 4'ha
`define PAR_IDX_CURR_HI 4'hb
`define PAR_IDX_TEMP_LO 4'hc
`define PAR_IDX_TEMP_HI 4'hd

// Address fields: port above the select code
`define PAR_ADR_PORT_HI 7
`define PAR_ADR_PORT_LO 6
`define PAR_ADR_IDX_HI 5
`define PAR_ADR_IDX_LO 2

// Completion flag position in an upper register
`define PAR_FLAG_BIT 7

// Preset value of every register
`define PAR_RST_VAL 8'h00

`endif

//--- design/par_pkg.sv
// Types shared by the port result register block.
// Assumes the map header sits beside it on the include path.
`include "par_map.svh"

package par_pkg;

    // One converter event: start or finish of a conversion
    typedef struct packed {
        logic valid;
        logic [1:0] port;
        logic [1:0] kind;
        logic [`PAR_RES_W-1:0] data;
    } par_conv_t;

    // Flag matrix, one bit per port and quantity
    typedef logic [`PAR_PORTS-1:0][`PAR_KINDS-1:0] par_flags_t;

    // Whole state of the block
    typedef struct packed {
        logic [`PAR_PORTS-1:0][`PAR_KINDS-1:0][`PAR_RES_W-1:0] res;
        par_flags_t done;
        par_flags_t sts;
        par_flags_t msk;
        logic ack;
        logic [31:0] dat;
        logic irq;
    } par_state_t;

endpackage : par_pkg

//--- test/par_top_bench.sv
// Self-checking bench for the port result register block.
// Assumes par_top on one clock, driven as a classic Wishbone master and converter.
`timescale 1ns/1ps
`include "par_map.svh"

`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin bad_count++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end

module par_top_bench;
    import par_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic irq_o;
    par_conv_t conv_start_i = '0;
    par_conv_t conv_done_i = '0;
    int bad_count = 0;
    int num_checks = 0;
    logic [31:0] exp_q[$];
    logic [`PAR_RES_W-1:0] res_m[4][3];
    logic [31:0] exp_now;
    logic [31:0] rnd;

    par_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_start_i(conv_start_i),
        .conv_done_i(conv_done_i), .irq_o(irq_o));

    // Clock, 8 ns period
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    // One bus cycle, entered just after a rising edge
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        // Hold until ack is sampled high at a rising edge, the watchdog ends a hang
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
        begin
            @(posedge clk_i);
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    // Read with the expected value noted for the watcher
    task automatic rd(input logic [7:0] adr, input logic [31:0] ex);
        exp_q.push_back(ex);
        bus(1'b0, adr, 32'h0000_0000);
    endtask : rd

    // Both halves of one port and quantity
    task automatic chk(input int p, input int k, input logic fl);
        rd(8'(p * 64 + (8 + 2 * k) * 4), {24'h00_0000, res_m[p][k][7:0]});
        rd(8'(p * 64 + (9 + 2 * k) * 4), {24'h00_0000, fl, res_m[p][k][14:8]});
    endtask : chk

    // One converter event pulse
    task automatic conv(input logic st, input int p, input int k, input logic [14:0] d);
        if (st)
            conv_start_i <= '{1'b1, 2'(p), 2'(k), 15'h0000};
        else
            conv_done_i <= '{1'b1, 2'(p), 2'(k), d};
        @(posedge clk_i);
        if (st)
            conv_start_i.valid <= 1'b0;
        else
            conv_done_i.valid <= 1'b0;
    endtask : conv

    task automatic irq_is(input logic ex);
        @(negedge clk_i);
        `CHK("irq_o", ex, irq_o)
        @(posedge clk_i);
    endtask : irq_is

    // Watcher: compares every read answer with the oldest note
    always @(negedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
        begin
            if (exp_q.size() == 0)
            begin
                bad_count++;
                $display("Error wb_dat_o expected none seen %h", wb_dat_o);
            end
            else
            begin
                exp_now = exp_q.pop_front();
                `CHK("wb_dat_o", exp_now, wb_dat_o)
            end
        end
    end

    task automatic close_out();
        // Notes left over mean reads that never got an answer
        if (exp_q.size() != 0)
        begin
            bad_count++;
            $display("Error exp_q expected 0 seen %0d", exp_q.size());
        end
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    // Watchdog, about thirteen times the expected run
    initial
    begin
        #40000;
        bad_count++;
        $display("Error watchdog expected finish seen timeout");
        close_out();
    end

    // Main sequence
    initial
    begin
        void'($urandom(32'hc6bb));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int p = 0; p < 4; p++)
            for (int k = 0; k < 3; k++)
            begin
                res_m[p][k] = 15'h0000;
                chk(p, k, 1'b0);
            end
        $display("test reset values done");
        // Start clears flag, done fills result and sets flag
        for (int p = 0; p < 4; p++)
            for (int k = 0; k < 3; k++)
            begin
                conv(1'b1, p, k, 15'h0000);
                chk(p, k, 1'b0);
                res_m[p][k] = 15'($urandom);
                conv(1'b0, p, k, res_m[p][k]);
                chk(p, k, 1'b1);
            end
        for (int p = 0; p < 4; p++)
            for (int k = 0; k < 3; k++)
                chk(p, k, 1'b1);
        // Start and finish in one cycle, finish wins
        res_m[3][0] = 15'($urandom);
        conv_start_i <= '{1'b1, 2'h3, 2'h0, 15'h0000};
        conv(1'b0, 3, 0, res_m[3][0]);
        conv_start_i.valid <= 1'b0;
        chk(3, 0, 1'b1);
        $display("test conversions done");
        // Restart keeps old value, clears flag only
        conv(1'b1, 0, 1, 15'h0000);
        chk(0, 1, 1'b0);
        conv(1'b0, 0, 1, res_m[0][1]);
        // Result registers ignore writes, unmapped place reads zero
        bus(1'b1, 8'ha0, 32'hffff_ffff);
        chk(2, 0, 1'b1);
        rd(8'h7c, 32'h0000_0000);
        $display("test read-only done");
        // Interrupt masked, unmasked, cleared, raised again
        irq_is(1'b0);
        bus(1'b1, 8'h04, 32'h0000_0020);
        irq_is(1'b1);
        rd(8'h00, 32'h0000_0fff);
        bus(1'b1, 8'h00, 32'h0000_0020);
        irq_is(1'b0);
        conv(1'b0, 1, 2, 15'h1234);
        irq_is(1'b1);
        res_m[1][2] = 15'h1234;
        chk(1, 2, 1'b1);
        bus(1'b1, 8'h00, 32'h0000_0fff);
        irq_is(1'b0);
        rd(8'h00, 32'h0000_0000);
        // Lane one alone reaches mask bits 11..8
        rnd = $urandom;
        wb_sel_i <= 4'h2;
        bus(1'b1, 8'h04, rnd);
        wb_sel_i <= 4'hf;
        rd(8'h04, {20'h0_0000, rnd[11:8], 8'h20});
        res_m[3][2] = 15'($urandom);
        conv(1'b0, 3, 2, res_m[3][2]);
        irq_is(rnd[11]);
        chk(3, 2, 1'b1);
        $display("test interrupt done");
        close_out();
    end
endmodule : par_top_bench
